/* hdl/oled_command_decoder.sv */
// command decoder with apb byte port, serial byte port and display ram
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module oled_command_decoder
    import oled_cmd_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial byte pins
    input wire logic ser_clk,
    input wire logic serial_data_in,
    input wire logic ser_cs_n,
    input wire logic ser_dc,
    // addressing
    output logic [1:0] addr_mode,
    output logic [7:0] col_ptr,
    output logic [2:0] page_ptr,
    output logic [7:0] col_start,
    output logic [7:0] col_end,
    output logic [2:0] page_start,
    output logic [2:0] page_end,
    // scan and mapping
    output logic [5:0] start_line,
    output logic seg_remap,
    output logic entire_on,
    output logic inverse,
    output logic [5:0] mux_n,
    output logic com_reverse,
    output logic [5:0] display_offset,
    output logic [3:0] clk_divide,
    output logic [3:0] osc_freq,
    // drive levels and colors
    output logic [7:0] contrast,
    output logic [7:0] brightness,
    output logic [7:0] dim_contrast,
    output logic [7:0] dim_brightness,
    output logic [5:0] lut_bank0,
    output logic [5:0] lut_a,
    output logic [5:0] lut_b,
    output logic [5:0] lut_c,
    output logic [63:0] bank_color,
    // power state and read-modify-write mode
    output logic [1:0] display_state,
    output logic rmw_mode
);
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    logic [3:0] pin_raw, pin_stable;
    logic sclk_prev_reg;
    logic [6:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic ser_valid_reg, ser_dc_reg;
    logic [7:0] ser_byte_reg;
    logic [10:0] ram_idx_reg;
    logic [7:0] display_ram [0:RAM_WORDS-1];
    dec_state_t state_reg;
    logic [7:0] opcode_reg;
    logic [1:0] pidx_reg;
    logic [2:0] pleft_reg;
    logic [1:0] addr_mode_reg;
    logic [7:0] col_reg, col_start_reg, col_end_reg, rmw_col_reg;
    logic [2:0] page_reg, page_start_reg, page_end_reg;
    logic [5:0] start_line_reg, mux_n_reg, offset_reg;
    logic seg_remap_reg, entire_on_reg, inverse_reg, com_rev_reg, rmw_reg;
    logic [3:0] clk_div_reg, osc_reg;
    logic [7:0] contrast_reg, bright_reg, dim_con_reg, dim_bri_reg;
    logic [5:0] lut0_reg, luta_reg, lutb_reg, lutc_reg;
    logic [63:0] bank_color_reg;
    logic [1:0] disp_reg;
    logic apb_done, apb_cmd, apb_dat, sclk_rise;
    logic byte_valid, byte_is_data, op_hit, param_hit, dat_hit;
    logic [7:0] byte_val;
    logic [10:0] wr_idx;

    // number of parameter bytes that follow each opcode
    function automatic logic [2:0] param_count(input logic [7:0] op);
        case (op)
            8'h20, 8'h81, 8'h82, 8'ha8, 8'hd3, 8'hd5: param_count = 3'h1;
            8'hd8, 8'hd9, 8'hda, 8'hdb: param_count = 3'h1;
            8'h21, 8'h22: param_count = 3'h2;
            8'hab: param_count = 3'h3;
            8'h91, 8'h92, 8'h93: param_count = 3'h4;
            default: param_count = 3'h0;
        endcase
    endfunction

    // apb slave, one wait state per access
    assign apb_done = psel & penable & pready_reg;
    assign apb_cmd = apb_done & pwrite & (paddr == ADDR_CMD);
    assign apb_dat = apb_done & pwrite & (paddr == ADDR_DATA);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= psel & penable & ~pready_reg;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end else if (psel & penable & ~pready_reg) begin
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
            if (paddr == ADDR_CMD || paddr == ADDR_DATA) begin
                prdata_reg <= 32'h0;
            end else if (paddr == ADDR_STATUS) begin
                prdata_reg <= {25'h0, pleft_reg, rmw_reg, disp_reg,
                    state_reg == ST_PARAM};
            end else if (paddr == ADDR_PTR) begin
                prdata_reg <= {5'h0, page_reg, col_end_reg, col_start_reg, col_reg};
            end else if (paddr == ADDR_LEVEL) begin
                prdata_reg <= {dim_bri_reg, dim_con_reg, bright_reg, contrast_reg};
            end else if (paddr == ADDR_MODE) begin
                prdata_reg <= {2'h0, addr_mode_reg, seg_remap_reg, entire_on_reg,
                    inverse_reg, com_rev_reg, mux_n_reg, offset_reg,
                    page_start_reg, page_end_reg, start_line_reg};
            end else if (paddr == ADDR_RAM) begin
                prdata_reg <= {13'h0, ram_idx_reg, display_ram[ram_idx_reg]};
            end else begin
                pslverr_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ram_idx_reg <= 11'h0;
        end else if (apb_done & pwrite & (paddr == ADDR_RAM)) begin
            ram_idx_reg <= pwdata[10:0];
        end
    end

    // pin synchronisers; a change counts once stages two and three agree
    assign pin_raw = {ser_cs_n, ser_dc, serial_data_in, ser_clk};
    generate
        for (genvar gi = 0; gi < 4; gi++) begin : g_sync
            logic s1, s2, s3, st;
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    s1 <= SYNC_RESET[gi];
                    s2 <= SYNC_RESET[gi];
                    s3 <= SYNC_RESET[gi];
                    st <= SYNC_RESET[gi];
                end else begin
                    s1 <= pin_raw[gi];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        st <= s3;
                    end
                end
            end
            assign pin_stable[gi] = st;
        end
    endgenerate

    assign sclk_rise = pin_stable[0] & ~sclk_prev_reg;

    // serial shifter, msb first; a deselect drops any partial byte
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_prev_reg <= 1'b0;
            shift_reg <= 7'h0;
            bit_cnt_reg <= 3'h0;
            ser_byte_reg <= 8'h0;
            ser_dc_reg <= 1'b0;
            ser_valid_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= pin_stable[0];
            if (ser_valid_reg & ~(apb_cmd | apb_dat)) begin
                ser_valid_reg <= 1'b0;
            end
            if (pin_stable[3]) begin
                bit_cnt_reg <= 3'h0;
            end else if (sclk_rise) begin
                shift_reg <= {shift_reg[5:0], pin_stable[1]};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    ser_byte_reg <= {shift_reg, pin_stable[1]};
                    ser_dc_reg <= pin_stable[2];
                    ser_valid_reg <= 1'b1;
                end
            end
        end
    end

    // apb wins a tie; the serial byte waits one cycle, it is not lost
    assign byte_valid = apb_cmd | apb_dat | ser_valid_reg;
    assign byte_val = (apb_cmd | apb_dat) ? pwdata[7:0] : ser_byte_reg;
    assign byte_is_data = (apb_cmd | apb_dat) ? apb_dat : ser_dc_reg;
    assign op_hit = byte_valid & ~byte_is_data & (state_reg == ST_OPCODE);
    assign param_hit = byte_valid & ~byte_is_data & (state_reg == ST_PARAM);
    assign dat_hit = byte_valid & byte_is_data;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_OPCODE;
            opcode_reg <= 8'h0;
            pidx_reg <= 2'h0;
            pleft_reg <= 3'h0;
        end else if (op_hit && param_count(byte_val) != 3'h0) begin
            state_reg <= ST_PARAM;
            opcode_reg <= byte_val;
            pidx_reg <= 2'h0;
            pleft_reg <= param_count(byte_val);
        end else if (param_hit) begin
            pidx_reg <= pidx_reg + 2'h1;
            pleft_reg <= pleft_reg - 3'h1;
            if (pleft_reg == 3'h1) begin
                state_reg <= ST_OPCODE;
            end
        end
    end

    assign wr_idx = 11'(page_reg) * RAM_COLS + 11'(col_reg);
    always_ff @(posedge clk) begin
        if (dat_hit) begin
            display_ram[wr_idx] <= byte_val;
        end
    end

    // column and page pointers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            col_reg <= 8'h0;
            page_reg <= 3'h0;
            rmw_col_reg <= 8'h0;
        end else if (op_hit) begin
            if (byte_val[7:4] == 4'h0) begin
                col_reg[3:0] <= byte_val[3:0];
            end else if (byte_val[7:4] == 4'h1) begin
                col_reg[7:4] <= byte_val[3:0];
            end else if (byte_val[7:3] == 5'h16) begin
                page_reg <= byte_val[2:0];
            end else if (byte_val == 8'he0) begin
                rmw_col_reg <= col_reg;
            end else if (byte_val == 8'hee && rmw_reg) begin
                col_reg <= rmw_col_reg;
            end
        end else if (param_hit) begin
            if (opcode_reg == 8'h21 && pidx_reg == 2'h0 && byte_val <= COL_MAX) begin
                col_reg <= byte_val;
            end else if (opcode_reg == 8'h22 && pidx_reg == 2'h0) begin
                page_reg <= byte_val[2:0];
            end
        end else if (dat_hit) begin
            case (addr_mode_reg)
                MODE_HORZ: begin
                    if (col_reg == col_end_reg) begin
                        col_reg <= col_start_reg;
                        page_reg <= (page_reg == page_end_reg) ? page_start_reg :
                            page_reg + 3'h1;
                    end else begin
                        col_reg <= col_reg + 8'h1;
                    end
                end
                MODE_VERT: begin
                    if (page_reg == page_end_reg) begin
                        page_reg <= page_start_reg;
                        col_reg <= (col_reg == col_end_reg) ? col_start_reg :
                            col_reg + 8'h1;
                    end else begin
                        page_reg <= page_reg + 3'h1;
                    end
                end
                default: begin
                    col_reg <= (col_reg == COL_MAX) ? 8'h0 : col_reg + 8'h1;
                end
            endcase
        end
    end

    // addressing window
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_mode_reg <= MODE_PAGE;
            col_start_reg <= 8'h0;
            col_end_reg <= COL_MAX;
            page_start_reg <= 3'h0;
            page_end_reg <= PAGE_MAX;
        end else if (param_hit) begin
            if (opcode_reg == 8'h20 && byte_val[1:0] != MODE_BAD) begin
                addr_mode_reg <= byte_val[1:0];
            end
            if (opcode_reg == 8'h21 && byte_val <= COL_MAX) begin
                if (pidx_reg == 2'h0) begin
                    col_start_reg <= byte_val;
                end else begin
                    col_end_reg <= byte_val;
                end
            end
            if (opcode_reg == 8'h22) begin
                if (pidx_reg == 2'h0) begin
                    page_start_reg <= byte_val[2:0];
                end else begin
                    page_end_reg <= byte_val[2:0];
                end
            end
        end
    end

    // single-byte display options
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_line_reg <= 6'h0;
            seg_remap_reg <= 1'b0;
            entire_on_reg <= 1'b0;
            inverse_reg <= 1'b0;
            com_rev_reg <= 1'b0;
            disp_reg <= DISP_OFF;
            rmw_reg <= 1'b0;
        end else if (op_hit) begin
            if (byte_val[7:6] == 2'h1) begin
                start_line_reg <= byte_val[5:0];
            end
            if (byte_val[7:1] == 7'h50) begin
                seg_remap_reg <= byte_val[0];
            end
            if (byte_val[7:1] == 7'h52) begin
                entire_on_reg <= byte_val[0];
            end
            if (byte_val[7:1] == 7'h53) begin
                inverse_reg <= byte_val[0];
            end
            if (byte_val == 8'hac) begin
                disp_reg <= DISP_DIM;
            end else if (byte_val == 8'hae) begin
                disp_reg <= DISP_OFF;
            end else if (byte_val == 8'haf) begin
                disp_reg <= DISP_NORMAL;
            end
            if ((byte_val & 8'hf7) == 8'hc0) begin
                com_rev_reg <= byte_val[3];
            end
            // rmw enter and exit, e3 falls through untouched
            if (byte_val == 8'he0) begin
                rmw_reg <= 1'b1;
            end else if (byte_val == 8'hee) begin
                rmw_reg <= 1'b0;
            end
        end
    end

    // scan timing parameters
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mux_n_reg <= RST_MUX_N;
            offset_reg <= 6'h0;
            clk_div_reg <= RST_CLK_DIV;
            osc_reg <= RST_OSC;
        end else if (param_hit) begin
            if (opcode_reg == 8'ha8 && byte_val[5:0] >= MUX_MIN_N) begin
                mux_n_reg <= byte_val[5:0];
            end
            if (opcode_reg == 8'hd3) begin
                offset_reg <= byte_val[5:0];
            end
            if (opcode_reg == 8'hd5) begin
                clk_div_reg <= byte_val[3:0];
                osc_reg <= byte_val[7:4];
            end
        end
    end

    // drive levels
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            contrast_reg <= RST_LEVEL;
            bright_reg <= RST_LEVEL;
            dim_con_reg <= 8'h0;
            dim_bri_reg <= 8'h0;
        end else if (param_hit) begin
            if (opcode_reg == 8'h81) begin
                contrast_reg <= byte_val;
            end
            if (opcode_reg == 8'h82) begin
                bright_reg <= byte_val;
            end
            if (opcode_reg == 8'hab && pidx_reg == 2'h1) begin
                dim_con_reg <= byte_val;
            end else if (opcode_reg == 8'hab && pidx_reg == 2'h2) begin
                dim_bri_reg <= byte_val;
            end
        end
    end

    // pulse widths and bank colors
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lut0_reg <= RST_LUT_BANK0;
            luta_reg <= RST_LUT_COLOR;
            lutb_reg <= RST_LUT_COLOR;
            lutc_reg <= RST_LUT_COLOR;
            bank_color_reg <= 64'h0;
        end else if (param_hit) begin
            if (opcode_reg == 8'h91) begin
                case (pidx_reg)
                    2'h0: lut0_reg <= byte_val[5:0];
                    2'h1: luta_reg <= byte_val[5:0];
                    2'h2: lutb_reg <= byte_val[5:0];
                    default: lutc_reg <= byte_val[5:0];
                endcase
            end
            if (opcode_reg == 8'h92) begin
                bank_color_reg[{1'b0, pidx_reg, 3'h0} +: 8] <= byte_val;
            end else if (opcode_reg == 8'h93) begin
                bank_color_reg[{1'b1, pidx_reg, 3'h0} +: 8] <= byte_val;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign addr_mode = addr_mode_reg;
    assign col_ptr = col_reg;
    assign page_ptr = page_reg;
    assign col_start = col_start_reg;
    assign col_end = col_end_reg;
    assign page_start = page_start_reg;
    assign page_end = page_end_reg;
    assign start_line = start_line_reg;
    assign seg_remap = seg_remap_reg;
    assign entire_on = entire_on_reg;
    assign inverse = inverse_reg;
    assign mux_n = mux_n_reg;
    assign com_reverse = com_rev_reg;
    assign display_offset = offset_reg;
    assign clk_divide = clk_div_reg;
    assign osc_freq = osc_reg;
    assign contrast = contrast_reg;
    assign brightness = bright_reg;
    assign dim_contrast = dim_con_reg;
    assign dim_brightness = dim_bri_reg;
    assign lut_bank0 = lut0_reg;
    assign lut_a = luta_reg;
    assign lut_b = lutb_reg;
    assign lut_c = lutc_reg;
    assign bank_color = bank_color_reg;
    assign display_state = disp_reg;
    assign rmw_mode = rmw_reg;
endmodule // oled_command_decoder
`default_nettype wire

/* hdl/oled_cmd_pkg.sv */
// constants and types shared by the display command decoder
// Summary of operation
// - opcodes 00-0F load the low nibble of the page-mode column pointer, reset 0
// - opcodes 10-1F load the high nibble of the page-mode column pointer, reset 0
// - opcode 20 plus one byte picks addressing scheme, 11b ignored, reset page
// - opcode 21 plus two bytes sets column start and end, 0 to 131
// - opcode 22 plus two bytes sets page start and end, 0 to 7
// - opcodes 40-7F set the RAM row shown on the first line, reset 0
// - opcode 81 plus one byte sets contrast, reset 80h
// - opcode 82 plus one byte sets brightness, reset 80h
// - opcode 91 plus four bytes sets pulse widths of bank 0 and colors A-C
// - opcodes 92 and 93 plus four bytes assign colors to banks 1-32
// - opcodes A0 and A1 choose segment mapping, reset normal
// - opcode A5 forces all pixels on, A4 follows RAM, reset A4
// - opcode A6 normal polarity, A7 inverted, reset normal
// - opcode A8 plus N sets multiplex N+1, N below 15 ignored, reset 64
// - opcode AB plus reserved byte, dim contrast and dim brightness
// - opcode AC dim on, AE off, AF normal on, reset off
// - opcodes B0-B7 load the page pointer for page addressing
// - bit 3 of C0/C8 picks common scan direction, reset upward
// - opcode D3 plus one byte sets vertical shift 0 to 63
// - opcode D5 plus byte sets clock divide low nibble, oscillator high nibble
// - E0 enters read-modify-write, EE leaves it, E3 does nothing
// - select low routes bytes to decoder, high routes them to display RAM
// - serial select sampled at eighth clock, byte delivered then
// - each data byte fills one 8-row column, bit 0 at top
package oled_cmd_pkg;
    // apb byte addresses
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PTR = 8'h0c;
    localparam logic [7:0] ADDR_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_MODE = 8'h14;
    localparam logic [7:0] ADDR_RAM = 8'h18;
    // addressing schemes
    localparam logic [1:0] MODE_HORZ = 2'h0;
    localparam logic [1:0] MODE_VERT = 2'h1;
    localparam logic [1:0] MODE_PAGE = 2'h2;
    localparam logic [1:0] MODE_BAD = 2'h3;
    // display power states
    localparam logic [1:0] DISP_OFF = 2'h0;
    localparam logic [1:0] DISP_DIM = 2'h1;
    localparam logic [1:0] DISP_NORMAL = 2'h2;
    // reset values and limits
    localparam logic [7:0] COL_MAX = 8'h83;
    localparam logic [2:0] PAGE_MAX = 3'h7;
    localparam logic [7:0] RST_LEVEL = 8'h80;
    localparam logic [5:0] RST_LUT_BANK0 = 6'h31;
    localparam logic [5:0] RST_LUT_COLOR = 6'h3f;
    localparam logic [5:0] RST_MUX_N = 6'h3f;
    localparam logic [5:0] MUX_MIN_N = 6'h0f;
    localparam logic [3:0] RST_CLK_DIV = 4'h0;
    localparam logic [3:0] RST_OSC = 4'h7;
    localparam logic [10:0] RAM_COLS = 11'h084;
    localparam int RAM_WORDS = 1056;
    localparam logic [3:0] SYNC_RESET = 4'h8;
    typedef enum logic {ST_OPCODE, ST_PARAM} dec_state_t;
endpackage

/* test/oled_cmd_sva.sv */
// port-level checks for the display command decoder
`timescale 1ns/1ps
`default_nettype none
module oled_cmd_sva
    import oled_cmd_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // settings
    input wire logic [7:0] contrast,
    input wire logic [1:0] addr_mode,
    input wire logic [5:0] mux_n,
    input wire logic inverse,
    input wire logic [1:0] display_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // serial commands bypass this, so the bench sends these opcodes over apb only
    wire cmd_wr = psel && penable && pready && pwrite && paddr == ADDR_CMD;
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered");
    a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    a_reset_load: assert property ($fell(sys_rst) |-> contrast == RST_LEVEL
        && addr_mode == MODE_PAGE && mux_n == RST_MUX_N) else $error("reset levels wrong");
    a_inverse_cmd: assert property ($changed(inverse) |->
        $past(cmd_wr && pwdata[7:1] == 7'h53) && inverse == $past(pwdata[0]))
        else $error("polarity changed without its opcode");
    a_power_cmd: assert property ($changed(display_state) |-> $past(cmd_wr) &&
        display_state == ($past(pwdata[0]) ? DISP_NORMAL : $past(pwdata[1]) ? DISP_OFF : DISP_DIM))
        else $error("power state wrong");
    a_mux_floor: assert property (mux_n >= MUX_MIN_N)
        else $error("multiplex below floor");
    a_contrast_cmd: assert property ($changed(contrast) |->
        $past(cmd_wr) && contrast == $past(pwdata[7:0])) else $error("contrast wrong");
endmodule // oled_cmd_sva
bind oled_command_decoder oled_cmd_sva u_sva (.*);
`default_nettype wire

/* test/oled_serial_host.sv */
// serial host model: bytes msb first with a data/command level
`timescale 1ns/1ps
`default_nettype none
module oled_serial_host (
    // system
    input wire logic clk,
    // serial pins
    output logic ser_clk,
    output logic serial_data_in,
    output logic ser_cs_n,
    output logic ser_dc
);
    initial begin
        ser_clk = 1'b0;
        serial_data_in = 1'b0;
        ser_cs_n = 1'b1;
        ser_dc = 1'b1;
    end
    task automatic send(input logic [7:0] b, input logic dc);
        @(posedge clk);
        ser_cs_n <= 1'b0;
        ser_dc <= dc;
        for (int i = 7; i >= 0; i--) begin
            serial_data_in <= b[i];
            repeat (5) @(posedge clk);
            ser_clk <= 1'b1;
            repeat (5) @(posedge clk);
            ser_clk <= 1'b0;
        end
        repeat (5) @(posedge clk);
        ser_cs_n <= 1'b1;
        // released line shows no stale bit
        serial_data_in <= ~b[0];
    endtask
endmodule // oled_serial_host
`default_nettype wire

/* test/oled_command_decoder_tb.sv */
// self-checking bench for the display command decoder
`timescale 1ns/1ps
`default_nettype none
module oled_command_decoder_tb
    import oled_cmd_pkg::*;
;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic ser_clk, serial_data_in, ser_cs_n, ser_dc, seg_remap, entire_on, inverse, com_reverse;
    logic rmw_mode;
    logic [7:0] paddr, col_ptr, col_start, col_end, contrast, brightness, dim_contrast;
    logic [7:0] dim_brightness;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] addr_mode, display_state;
    logic [2:0] page_ptr, page_start, page_end;
    logic [5:0] start_line, mux_n, display_offset, lut_bank0, lut_a, lut_b, lut_c;
    logic [3:0] clk_divide, osc_freq;
    logic [63:0] bank_color;
    int failures = 0, compares = 0, n;
    oled_command_decoder DUT (.*);
    oled_serial_host hst (.*);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) failures++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] b);
        apb(1'b1, ADDR_CMD, {24'h0, b});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic t_reset;
        rd(ADDR_LEVEL, 32'h0000_8080);
        rd(ADDR_MODE, 32'h20fc_01c0);
        rd(ADDR_PTR, 32'h0083_0000);
        rd(ADDR_STATUS, 32'h0);
        chk({lut_bank0, lut_a, lut_b, lut_c, clk_divide, osc_freq},
            {RST_LUT_BANK0, RST_LUT_COLOR, RST_LUT_COLOR, RST_LUT_COLOR, RST_CLK_DIV, RST_OSC});
    endtask
    task automatic t_cmds;
        logic [7:0] seq [$] = '{8'h81, 8'h55, 8'h20, 8'h00, 8'h20, 8'h03, 8'ha8, 8'h0f, 8'ha8,
            8'h0e, 8'ha7, 8'haf, 8'h21, 8'h02, 8'h80, 8'h22, 8'h01, 8'h06, 8'h05, 8'h1a, 8'hb3,
            8'h4a, 8'h92, 8'he4, 8'h1b, 8'h00, 8'hff, 8'hab, 8'h00, 8'h11, 8'h22, 8'he0, 8'he3,
            8'ha1, 8'ha5, 8'hc8, 8'hd3, 8'h2a, 8'hd5, 8'hf3, 8'h91, 8'h1f, 8'h20, 8'h21, 8'h22,
            8'h93, 8'h01, 8'h02, 8'h03, 8'h04, 8'hd8, 8'h4f};
        foreach (seq[i]) cmd(seq[i]);
        chk({contrast, addr_mode, mux_n, inverse}, {8'h55, MODE_HORZ, 6'h0f, 1'b1});
        chk({col_start, col_end, col_ptr, page_ptr}, {8'h02, 8'h80, 8'ha5, 3'h3});
        chk({start_line, bank_color[31:0], rmw_mode}, {6'h0a, 32'hff001be4, 1'b1});
        chk({seg_remap, entire_on, com_reverse}, 3'h7);
        chk(display_offset, 6'h2a);
        chk({clk_divide, osc_freq}, 8'h3f);
        chk({page_start, page_end}, {3'h1, 3'h6});
        chk({lut_bank0, lut_a, lut_b, lut_c}, {6'h1f, 6'h20, 6'h21, 6'h22});
        chk(bank_color[63:32], 32'h04030201);
        rd(ADDR_LEVEL, 32'h2211_8055);
        cmd(8'hac);
        chk(display_state, DISP_DIM);
        cmd(8'hee);
        cmd(8'hae);
        chk({rmw_mode, display_state}, {1'b0, DISP_OFF});
    endtask
    task automatic t_serial;
        hst.send(8'h82, 1'b0);
        hst.send(8'h96, 1'b1);
        hst.send(8'h3c, 1'b0);
        for (n = 0; n < 40 && brightness !== 8'h3c; n++) @(posedge clk);
        chk(brightness, 8'h3c);
        // data byte landed at page 3, column a5h
        apb(1'b1, ADDR_RAM, 32'h231);
        rd(ADDR_RAM, 32'h0002_3196);
    endtask
    task automatic t_refuse;
        apb(1'b1, 8'h1c, 32'hffff_ffff);
        chk(err, 1'b1);
        apb(1'b1, ADDR_LEVEL, 32'h0);
        rd(8'h1c, 32'h0);
        rd(ADDR_LEVEL, 32'h2211_3c55);
    endtask
    task automatic tally_and_finish;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #100us;
        failures++;
        tally_and_finish();
    end
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_cmds();
        t_serial();
        t_refuse();
        // a second reset mid-run must restore the defaults that t_reset checks; bank colors and the RAM index are not read back
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        tally_and_finish();
    end
endmodule // oled_command_decoder_tb
`default_nettype wire
